// *** rsc_params.svh ***
// constants for the reset source controller
// assumes one 50 MHz clock; included by the hold timer and the controller
`ifndef RSC_PARAMS_SVH
`define RSC_PARAMS_SVH
`define RSC_CLK_MHZ 50
`define RSC_CLK_PERIOD_NS 20
// external pin low time: 12 oscillator periods, here clock periods
`define RSC_EXT_MIN_CYCLES 12
// internal reset hold: 2**20 oscillator periods
`define RSC_HOLD_CYCLES 32'h0010_0000
`define RSC_TRAP_LO 16'h0000
`define RSC_TRAP_HI 16'h023F
`define RSC_VEC_ADDR 16'hFFFE
`define RSC_HFOSC_BIT 7
`define RSC_LFOSC_BIT 6
`endif

// *** rsc_pkg.sv ***
// types for the reset source controller
// uses no numeric constants from rsc_params.svh
package rsc_pkg;
  typedef enum logic [1:0] {RSC_RUN, RSC_EXT, RSC_INT} rsc_state_t;
endpackage

// *** rsc_hold_timer.sv ***
// hold timer: counts a fixed number of cycles after a start pulse
// assumes start comes from logic on ref_clk
`include "rsc_params.svh"
module rsc_hold_timer #(
  parameter logic [31:0] HOLD = `RSC_HOLD_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic start,
  output logic busy
);
  logic [31:0] cnt_reg, cnt_next;
  logic busy_reg, busy_next;

  // load on start, count down to release
  always_comb begin
    cnt_next = cnt_reg;
    busy_next = busy_reg;
    if (start) begin
      cnt_next = HOLD - 32'h0000_0001;
      busy_next = 1'b1;
    end else if (busy_reg) begin
      if (cnt_reg == 32'h0000_0000) begin
        busy_next = 1'b0;
      end else begin
        cnt_next = cnt_reg - 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_reg <= 32'h0000_0000;
      busy_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      busy_reg <= busy_next;
    end
  end

  assign busy = busy_reg;
endmodule // rsc_hold_timer

// *** rsc_reset_source_controller.sv ***
// reset source controller: merges pin, address-trap and clock resets
// assumes fetch bus and oscillator enables come from ref_clk logic;
// the reset pin is asynchronous and is synchronised here
//
// Notes on behaviour
// - pin low twelve cycles applies reset
// - pin high releases reset, fetch vector
// - fetch from low trap region raises reset
// - trap reset drives reset pin low
// - trap reset held 2**20 cycles
// - both oscillator enables cleared raises reset
// - clock reset drives pin low
// - clock reset held 2**20 cycles
`include "rsc_params.svh"
module rsc_reset_source_controller
  import rsc_pkg::*;
#(
  parameter logic [31:0] HOLD_CYCLES = `RSC_HOLD_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic reset_pin_n_in,
  output logic reset_pin_n_out,
  output logic reset_pin_oe_n,
  input wire logic fetch_valid,
  input wire logic [15:0] fetch_addr,
  input wire logic [7:0] system_control_two,
  output logic core_reset,
  output logic vector_fetch,
  output logic [15:0] vector_addr,
  output logic trap_active,
  output logic clock_fault_active
);
  localparam int EXT_MIN = `RSC_EXT_MIN_CYCLES;

  // all assertions below run on ref_clk and sleep through reset
  default clocking assert_clk @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);

  // two-stage synchroniser on the pin
  logic pin_s1_reg, pin_s2_reg;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      pin_s1_reg <= 1'b1;
      pin_s2_reg <= 1'b1;
    end else begin
      pin_s1_reg <= reset_pin_n_in;
      pin_s2_reg <= pin_s1_reg;
    end
  end

  // merged reset state; declared first, the detectors read it
  rsc_state_t state_reg, state_next;
  logic [3:0] low_cnt_reg, low_cnt_next;
  logic core_reset_reg, core_reset_next;
  logic vec_reg, vec_next;
  logic oe_n_reg, oe_n_next;
  logic trap_reg, clk_reg;
  logic trap_busy, clk_busy;
  logic trap_hit, clk_hit;
  logic int_any;

  // internal source detection
  // the trap region starts at address zero, so only its top needs a
  // compare; an unsigned test against zero would be constant
  assign trap_hit = fetch_valid && !core_reset_reg &&
                    fetch_addr <= `RSC_TRAP_HI;
  assign clk_hit = !system_control_two[`RSC_HFOSC_BIT] &&
                   !system_control_two[`RSC_LFOSC_BIT] &&
                   !clk_busy;

  // separate timers so the two causes stay visible apart
  // a clock fault that persists past its hold restarts the timer; the
  // pin then floats for one cycle between the two holds
  rsc_hold_timer #(.HOLD(HOLD_CYCLES)) u_trap_timer (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .start(trap_hit && !trap_busy),
    .busy(trap_busy)
  );
  rsc_hold_timer #(.HOLD(HOLD_CYCLES)) u_clk_timer (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .start(clk_hit),
    .busy(clk_busy)
  );

  // pin filter and merged reset state
  // own drive is seen on the pin; ignore pin low while driving it
  assign int_any = trap_busy || clk_busy;

  always_comb begin
    state_next = state_reg;
    low_cnt_next = low_cnt_reg;
    vec_next = 1'b0;
    oe_n_next = !int_any;
    core_reset_next = core_reset_reg;
    if (pin_s2_reg || int_any) begin
      low_cnt_next = 4'h0;
    end else if (low_cnt_reg < 4'(EXT_MIN)) begin
      low_cnt_next = low_cnt_reg + 4'h1;
    end
    case (state_reg)
      RSC_RUN: begin
        if (int_any) begin
          state_next = RSC_INT;
          core_reset_next = 1'b1;
        end else if (low_cnt_next == 4'(EXT_MIN)) begin
          state_next = RSC_EXT;
          core_reset_next = 1'b1;
        end
      end
      RSC_EXT: begin
        if (int_any) begin
          state_next = RSC_INT;
        end else if (pin_s2_reg) begin
          state_next = RSC_RUN;
          core_reset_next = 1'b0;
          vec_next = 1'b1;
        end
      end
      RSC_INT: begin
        if (!int_any && oe_n_reg) begin
          // wait one cycle for the pin to float back high
          state_next = RSC_EXT;
        end
      end
      default: begin
        state_next = RSC_RUN;
        core_reset_next = 1'b0;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= RSC_EXT;
      low_cnt_reg <= 4'h0;
      core_reset_reg <= 1'b1;
      vec_reg <= 1'b0;
      oe_n_reg <= 1'b1;
      trap_reg <= 1'b0;
      clk_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      low_cnt_reg <= low_cnt_next;
      core_reset_reg <= core_reset_next;
      vec_reg <= vec_next;
      oe_n_reg <= oe_n_next;
      trap_reg <= trap_busy;
      clk_reg <= clk_busy;
    end
  end

  // outputs straight from flip-flops, except the constant pin level and vector address
  assign core_reset = core_reset_reg;
  assign vector_fetch = vec_reg;
  assign vector_addr = `RSC_VEC_ADDR;
  assign reset_pin_n_out = 1'b0;
  assign reset_pin_oe_n = oe_n_reg;
  assign trap_active = trap_reg;
  assign clock_fault_active = clk_reg;

  // assertion helper: length of each hold, so that the full span is
  // checked without unrolling a long repetition
  logic [31:0] trap_len_reg, trap_len_next;
  logic [31:0] clk_len_reg, clk_len_next;
  always_comb begin
    trap_len_next = 32'h0000_0000;
    clk_len_next = 32'h0000_0000;
    if (trap_busy) begin
      trap_len_next = trap_len_reg + 32'h0000_0001;
    end
    if (clk_busy) begin
      clk_len_next = clk_len_reg + 32'h0000_0001;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      trap_len_reg <= 32'h0000_0000;
      clk_len_reg <= 32'h0000_0000;
    end else begin
      trap_len_reg <= trap_len_next;
      clk_len_reg <= clk_len_next;
    end
  end

  // the pin is driven one cycle after a timer starts
  a_pin_drive_trap: assert property (
    trap_busy |=> !reset_pin_oe_n)
    else $error("pin not driven in trap");
  a_pin_drive_clk: assert property (
    clk_busy |=> !reset_pin_oe_n)
    else $error("pin not driven on clk");
  a_pin_float_idle: assert property (
    !int_any |=> reset_pin_oe_n)
    else $error("pin driven while idle");

  // detection of both internal causes, and the merge of the trap cause into core_reset
  a_trap_start: assert property (
    trap_hit |=> trap_busy)
    else $error("trap fetch not caught");
  a_clk_start: assert property (
    clk_hit |=> clk_busy)
    else $error("clock fault not caught");
  a_trap_reset: assert property (
    trap_hit |-> ##2 core_reset)
    else $error("trap gave no reset");

  // hold spans: the repetition catches an early drop, the counter the end
  a_clk_holds: assert property (
    $rose(clk_busy) |-> clk_busy [*8])
    else $error("clock reset short");
  a_trap_span: assert property (
    $fell(trap_busy) |-> trap_len_reg == HOLD_CYCLES)
    else $error("trap hold length wrong");
  a_clk_span: assert property (
    $fell(clk_busy) |-> clk_len_reg == HOLD_CYCLES)
    else $error("clock hold length wrong");

  // pin filter: twelve synchronised low cycles, then reset
  sequence s_pin_low;
    !pin_s2_reg && !int_any && !core_reset_reg;
  endsequence
  a_ext_reset: assert property (
    s_pin_low [*8] ##1 s_pin_low [*4] |=> core_reset)
    else $error("external reset not applied");
  a_ext_short: assert property (
    !core_reset && $past(pin_s2_reg) && pin_s2_reg && !int_any
    |=> !core_reset)
    else $error("reset without low pin");
  a_vector_release: assert property (
    $fell(core_reset) |-> vector_fetch)
    else $error("no vector fetch");
endmodule // rsc_reset_source_controller

// *** rsc_ext_reset_model.sv ***
// external supervisor model on the open-drain reset pin
// assumes a pull-up: it only pulls low, never drives high
module rsc_ext_reset_model (
  input wire logic ref_clk,
  input wire logic start,
  input wire logic [7:0] width,
  output logic drive_low
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] left_reg = 8'h00;
  // pulls low for width cycles; 12 or more makes a valid reset
  always @(posedge ref_clk) begin
    if (start) left_reg <= width;
    else if (left_reg != 8'h00) left_reg <= left_reg - 8'h01;
  end
  assign drive_low = (left_reg != 8'h00);
endmodule // rsc_ext_reset_model

// *** testbench.sv ***
// bench for the reset source controller with a short hold count
// assumes the pin has a pull-up and is shared with the supervisor model
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int HOLD = 16;
  logic ref_clk = 0, rstn = 0, fetch_valid = 0, start = 0;
  logic [15:0] fetch_addr = 16'h0000;
  logic [7:0] scr = 8'hC0, width = 8'h00;
  logic pin_out, oe_n, ext_low, core_reset, vector_fetch, trap_active, cf;
  logic [15:0] vector_addr;
  int err_count = 0, total_checks = 0, n;
  // open-drain wire: either party pulls low, pull-up otherwise
  wire pin_n = (oe_n ? 1'b1 : pin_out) & ~ext_low;
  always #10 ref_clk = ~ref_clk;
  rsc_reset_source_controller #(.HOLD_CYCLES(32'h0000_0010)) dut (
    .ref_clk(ref_clk), .rstn(rstn), .reset_pin_n_in(pin_n),
    .reset_pin_n_out(pin_out), .reset_pin_oe_n(oe_n),
    .fetch_valid(fetch_valid), .fetch_addr(fetch_addr),
    .system_control_two(scr), .core_reset(core_reset),
    .vector_fetch(vector_fetch), .vector_addr(vector_addr),
    .trap_active(trap_active), .clock_fault_active(cf));
  rsc_ext_reset_model ext (.ref_clk(ref_clk), .start(start),
    .width(width), .drive_low(ext_low));
  task automatic check(string nm, logic [15:0] seen, logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic negs(int k);
    repeat (k) @(negedge ref_clk);
  endtask
  // waits bounded for the release pulse, then checks the run state
  task automatic released();
    for (int i = 0; i < 40 && vector_fetch !== 1'b1; i++) negs(1);
    check("vector_fetch", vector_fetch, 1);
    check("vector_addr", vector_addr, 16'hFFFE);
    check("core_reset", core_reset, 0);
    check("oe_n idle", oe_n, 1);
  endtask
  // counts the cycles the device keeps pulling the pin low
  task automatic hold_len(output int k);
    k = 0;
    while (oe_n === 1'b0 && k < 100) begin
      k++;
      negs(1);
    end
  endtask
  task automatic t_pin();
    @(posedge ref_clk) begin start <= 1; width <= 8'h08; end
    @(posedge ref_clk) start <= 0;
    negs(24);
    check("short pin", core_reset, 0);
    @(posedge ref_clk) begin start <= 1; width <= 8'h14; end
    @(posedge ref_clk) start <= 0;
    negs(18);
    check("long pin", core_reset, 1);
    check("pin not driven", oe_n, 1);
    released();
  endtask
  task automatic t_trap(logic [15:0] a, logic hit);
    @(posedge ref_clk) begin fetch_valid <= 1; fetch_addr <= a; end
    @(posedge ref_clk) fetch_valid <= 0;
    negs(5);
    check("trap_active", trap_active, hit);
    check("trap pin", oe_n, !hit);
    check("trap pin level", pin_n, !hit);
    check("trap core", core_reset, hit);
    if (hit) begin
      // three low cycles have passed before the count starts
      hold_len(n);
      check("trap hold", n + 3, HOLD);
      released();
    end
  endtask
  task automatic t_clk(logic [7:0] v, logic hit);
    @(posedge ref_clk) scr <= v;
    negs(5);
    check("clock fault", cf, hit);
    check("fault pin", oe_n, !hit);
    check("fault pin level", pin_n, !hit);
    @(posedge ref_clk) scr <= 8'hC0;
    if (hit) begin
      // count on negedges only, never in the launching time step
      negs(1);
      hold_len(n);
      check("fault hold", n + 3, HOLD);
      released();
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // main sequence: boot, pin filter, traps at both edges, clock faults
  initial begin
    repeat (8) @(posedge ref_clk);
    rstn <= 1;
    released();
    t_pin();
    t_trap(16'h0240, 0);
    t_trap(16'h023F, 1);
    t_trap(16'h0000, 1);
    t_clk(8'h40, 0);
    t_clk(8'h80, 0);
    t_clk(8'h3F, 1);
    results();
  end
  // cuts a hang short well beyond the expected run of under 150 cycles
  initial begin
    #200us;
    err_count++;
    results();
  end
endmodule // testbench
